// [hw/echo_frontend_config_regs.sv]
/*
 Configuration register bank of the echo receive front end, reached
 over a 16-bit serial frame. Assumes serial pins are synchronous to
 clk_in and that the clock is well above the serial bit rate.
*/
`timescale 1ns/1ps
`default_nettype none
module echo_frontend_config_regs (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   output echo_frontend_pkg::filter_ctrl_t filter_ctrl_out,
   output echo_frontend_pkg::logamp_ctrl_t logamp_ctrl_out,
   output logic [7:0] device_control_three_out
);
   import echo_frontend_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic odd_ok(input logic [15:0] f);
      odd_ok = ^f;
   endfunction : odd_ok

   function automatic logic [7:0] merge(input logic [7:0] old_v,
         input logic [7:0] new_v, input logic [7:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   // ==========================================================
   // Serial state
   spi_state_t state;
   spi_state_t next_state;
   logic sclk_d;
   logic [15:0] shift;
   logic [15:0] next_shift;
   logic [4:0] count;
   logic [4:0] next_count;
   logic [15:0] tx;
   logic [15:0] next_tx;
   logic parity_err;
   logic next_parity_err;
   logic sdo;
   logic next_sdo;
   logic sdo_oe;
   logic next_sdo_oe;

   // ==========================================================
   // Register state
   logic [7:0] filter_config_one;
   logic [7:0] filter_quality_trim;
   logic [7:0] logamp_slope_intercept;
   logic [7:0] logamp_stage_gain_ctrl;
   logic [7:0] device_control_three;
   logic [7:0] next_filter_config_one;
   logic [7:0] next_filter_quality_trim;
   logic [7:0] next_logamp_slope_intercept;
   logic [7:0] next_logamp_stage_gain_ctrl;
   logic [7:0] next_device_control_three;
   filter_ctrl_t filter_ctrl;
   filter_ctrl_t next_filter_ctrl;
   logamp_ctrl_t logamp_ctrl;
   logamp_ctrl_t next_logamp_ctrl;
   logic [7:0] dc3_q;
   logic [7:0] next_dc3_q;

   logic rise;
   logic fall;
   frame_t rx;
   logic [7:0] rd_data;
   logic [6:0] eff_freq;

   assign rise = sclk_in & ~sclk_d;
   assign fall = ~sclk_in & sclk_d;
   assign rx = frame_t'(shift);

   // ==========================================================
   // Read mux, addressed once eight header bits are in
   always_comb begin
      unique case (shift[6:1])
         OFS_FILTER_CONFIG_ONE: rd_data = filter_config_one;
         OFS_FILTER_QUALITY_TRIM: rd_data = filter_quality_trim;
         OFS_LOGAMP_SLOPE_INTERCEPT: rd_data = logamp_slope_intercept;
         OFS_LOGAMP_STAGE_GAIN_CTRL: rd_data = logamp_stage_gain_ctrl;
         OFS_DEVICE_CONTROL_THREE: rd_data = device_control_three;
         default: rd_data = 8'h00;
      endcase
   end

   // ==========================================================
   // Frame engine
   always_comb begin
      next_state = state;
      next_shift = shift;
      next_count = count;
      next_tx = tx;
      next_parity_err = parity_err;
      next_sdo = sdo;
      next_sdo_oe = sdo_oe;
      if (cs_n_in) begin
         next_state = ST_IDLE;
         next_count = 5'h00;
         next_sdo_oe = 1'b0;
         next_sdo = 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_tx = {parity_err, STATUS_BITS, ~parity_err, 8'h00};
               next_sdo = parity_err;
               next_sdo_oe = 1'b1;
               next_state = ST_SHIFT;
            end
            ST_SHIFT: begin
               if (fall) begin
                  next_shift = {shift[14:0], sdi_in};
                  next_count = count + 5'h01;
                  if (count == FRAME_LAST) begin
                     next_state = ST_DONE;
                  end
               end
               if (rise && count != 5'h00) begin
                  next_tx = {tx[14:0], 1'b0};
                  next_sdo = tx[14];
                  if (count == FRAME_DATA_START && shift[7]) begin
                     next_tx = {rd_data, 8'h00};
                     next_sdo = rd_data[7];
                  end
               end
            end
            ST_DONE: begin
               next_parity_err = ~odd_ok(shift);
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Register writes at frame end
   logic wr_now;
   assign wr_now = (state == ST_DONE) && cs_n_in && !rx.read_not_write
      && odd_ok(shift);

   always_comb begin
      next_filter_config_one = filter_config_one;
      next_filter_quality_trim = filter_quality_trim;
      next_logamp_slope_intercept = logamp_slope_intercept;
      next_logamp_stage_gain_ctrl = logamp_stage_gain_ctrl;
      next_device_control_three = device_control_three;
      if (wr_now) begin
         unique case (rx.addr)
            OFS_FILTER_CONFIG_ONE: next_filter_config_one = rx.data;
            OFS_FILTER_QUALITY_TRIM: next_filter_quality_trim = merge(
               filter_quality_trim, rx.data,
               WMASK_FILTER_QUALITY_TRIM);
            OFS_LOGAMP_SLOPE_INTERCEPT:
               next_logamp_slope_intercept = rx.data;
            OFS_LOGAMP_STAGE_GAIN_CTRL: next_logamp_stage_gain_ctrl = merge(
               logamp_stage_gain_ctrl, rx.data,
               WMASK_LOGAMP_STAGE_GAIN_CTRL);
            OFS_DEVICE_CONTROL_THREE: next_device_control_three = merge(
               device_control_three, rx.data, WMASK_FULL);
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Decoded controls
   always_comb begin
      eff_freq = {1'b0, filter_config_one[5:0]};
      if (filter_config_one[POS_TRIM_OVERRIDE]
            && !filter_config_one[POS_BYPASS]) begin
         eff_freq = {1'b0, filter_config_one[5:0]}
            + {3'h0, filter_quality_trim[3:0]};
      end
      next_filter_ctrl.bypass = filter_config_one[POS_BYPASS];
      next_filter_ctrl.quality_select = filter_config_one[POS_BYPASS] ?
         2'h0 : filter_quality_trim[5:4];
      next_filter_ctrl.freq_code = eff_freq[5:0];
      next_logamp_ctrl.first_stage_off =
         logamp_stage_gain_ctrl[POS_FIRST_OFF];
      next_logamp_ctrl.last_stage_off =
         logamp_stage_gain_ctrl[POS_LAST_OFF];
      next_logamp_ctrl.scale_5v =
         logamp_stage_gain_ctrl[POS_SCALE_SEL];
      next_logamp_ctrl.gain_code = logamp_stage_gain_ctrl[1:0];
      if (logamp_slope_intercept[POS_TRIM_OVERRIDE]) begin
         next_logamp_ctrl.slope_code = logamp_slope_intercept[6:4];
         next_logamp_ctrl.intercept_code = logamp_slope_intercept[3:0];
      end else begin
         next_logamp_ctrl.slope_code = 3'h0;
         next_logamp_ctrl.intercept_code = 4'h0;
      end
      next_dc3_q = device_control_three;
   end

   // ==========================================================
   // Serial flip-flops
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state <= ST_IDLE;
         sclk_d <= 1'b0;
         shift <= 16'h0000;
         count <= 5'h00;
         tx <= 16'h0000;
         parity_err <= 1'b0;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         state <= next_state;
         sclk_d <= sclk_in;
         shift <= next_shift;
         count <= next_count;
         tx <= next_tx;
         parity_err <= next_parity_err;
         sdo <= next_sdo;
         sdo_oe <= next_sdo_oe;
      end
   end

   // ==========================================================
   // Register flip-flops
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         filter_config_one <= RST_FILTER_CONFIG_ONE;
         filter_quality_trim <= RST_FILTER_QUALITY_TRIM;
         logamp_slope_intercept <= RST_LOGAMP_SLOPE_INTERCEPT;
         logamp_stage_gain_ctrl <= RST_LOGAMP_STAGE_GAIN_CTRL;
         device_control_three <= RST_DEVICE_CONTROL_THREE;
      end else begin
         filter_config_one <= next_filter_config_one;
         filter_quality_trim <= next_filter_quality_trim;
         logamp_slope_intercept <= next_logamp_slope_intercept;
         logamp_stage_gain_ctrl <= next_logamp_stage_gain_ctrl;
         device_control_three <= next_device_control_three;
      end
   end

   // ==========================================================
   // Decoded control flip-flops
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         filter_ctrl <= '0;
         logamp_ctrl <= '0;
         dc3_q <= 8'h00;
      end else begin
         filter_ctrl <= next_filter_ctrl;
         logamp_ctrl <= next_logamp_ctrl;
         dc3_q <= next_dc3_q;
      end
   end

   assign sdo_out = sdo;
   assign sdo_oe_out = sdo_oe;
   assign filter_ctrl_out = filter_ctrl;
   assign logamp_ctrl_out = logamp_ctrl;
   assign device_control_three_out = dc3_q;
endmodule : echo_frontend_config_regs
`default_nettype wire

// [hw/echo_frontend_pkg.sv]
/*
 Constants, field layouts and carrier types of the echo front-end
 configuration bank. Assumes a single 200 MHz clock domain.
*/
package echo_frontend_pkg;
   // ==========================================================
   // Register offsets (6-bit address)
   localparam logic [5:0] OFS_FILTER_CONFIG_ONE = 6'h10;
   localparam logic [5:0] OFS_FILTER_QUALITY_TRIM = 6'h11;
   localparam logic [5:0] OFS_LOGAMP_SLOPE_INTERCEPT = 6'h12;
   localparam logic [5:0] OFS_LOGAMP_STAGE_GAIN_CTRL = 6'h13;
   localparam logic [5:0] OFS_DEVICE_CONTROL_THREE = 6'h14;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_FILTER_CONFIG_ONE = 8'h00;
   localparam logic [7:0] RST_FILTER_QUALITY_TRIM = 8'h00;
   localparam logic [7:0] RST_LOGAMP_SLOPE_INTERCEPT = 8'h00;
   localparam logic [7:0] RST_LOGAMP_STAGE_GAIN_CTRL = 8'h00;
   localparam logic [7:0] RST_DEVICE_CONTROL_THREE = 8'h00;
   // ==========================================================
   // Writable bit masks
   localparam logic [7:0] WMASK_FILTER_QUALITY_TRIM = 8'h3F;
   localparam logic [7:0] WMASK_LOGAMP_STAGE_GAIN_CTRL = 8'hC7;
   localparam logic [7:0] WMASK_FULL = 8'hFF;
   // ==========================================================
   // Field positions
   localparam int POS_TRIM_OVERRIDE = 7;
   localparam int POS_BYPASS = 6;
   localparam int POS_FIRST_OFF = 7;
   localparam int POS_LAST_OFF = 6;
   localparam int POS_SCALE_SEL = 2;
   // ==========================================================
   // Serial frame layout
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] FRAME_LAST = 5'h0F;
   localparam logic [4:0] FRAME_DATA_START = 5'h08;
   localparam logic [5:0] STATUS_BITS = 6'h00;

   typedef struct packed {
      logic       read_not_write;
      logic [5:0] addr;
      logic       parity;
      logic [7:0] data;
   } frame_t;

   typedef struct packed {
      logic       bypass;
      logic [1:0] quality_select;
      logic [5:0] freq_code;
   } filter_ctrl_t;

   typedef struct packed {
      logic       first_stage_off;
      logic       last_stage_off;
      logic       scale_5v;
      logic [2:0] slope_code;
      logic [3:0] intercept_code;
      logic [1:0] gain_code;
   } logamp_ctrl_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE = 2'b10
   } spi_state_t;
endpackage : echo_frontend_pkg

// [testbench/echo_frontend_monitor.sv]
/*
 Port checker of the echo front-end register bank, bound to its top.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module echo_frontend_monitor (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   input wire logic sdo_out,
   input wire logic sdo_oe_out,
   input wire echo_frontend_pkg::filter_ctrl_t filter_ctrl_out,
   input wire echo_frontend_pkg::logamp_ctrl_t logamp_ctrl_out,
   input wire logic [7:0] device_control_three_out
);
   import echo_frontend_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ==========================================================
   // Frame steps
   sequence s_sel_start;
      $fell(cs_n_in);
   endsequence
   sequence s_idle_two;
      cs_n_in ##1 cs_n_in;
   endsequence
   // ==========================================================
   // Serial side
   a_select_drives_sdo: assert property (
      s_sel_start |-> ##[1:2] sdo_oe_out)
      else $error("sdo not driven after select");
   a_idle_releases_sdo: assert property (
      s_idle_two |-> !sdo_oe_out)
      else $error("sdo driven while deselected");
   a_frame_keeps_sdo: assert property (
      sdo_oe_out && !cs_n_in ##1 !cs_n_in |-> sdo_oe_out)
      else $error("sdo released inside frame");
   a_sdo_after_rise: assert property (
      !cs_n_in && sdo_oe_out && $past(sdo_oe_out) && $changed(sdo_out)
      |-> $past(sclk_in) || $past(sclk_in, 2) || $past(sclk_in, 3))
      else $error("sdo moved without a serial clock rise");
   // ==========================================================
   // Control outputs
   a_reset_clears: assert property (
      $rose(rstn_in) |-> {filter_ctrl_out, logamp_ctrl_out,
      device_control_three_out} == 29'h0)
      else $error("controls not zero after reset");
   a_bypass_q_zero: assert property (
      filter_ctrl_out.bypass |-> filter_ctrl_out.quality_select == 2'h0)
      else $error("quality select active in bypass");
   a_filter_quiet: assert property (
      $changed(filter_ctrl_out) |-> cs_n_in && $past(cs_n_in))
      else $error("filter controls moved inside frame");
   a_logamp_quiet: assert property (
      $changed(logamp_ctrl_out) |-> cs_n_in && $past(cs_n_in))
      else $error("log-amp controls moved inside frame");
   a_dc3_quiet: assert property (
      $changed(device_control_three_out) |-> cs_n_in && $past(cs_n_in))
      else $error("control three moved inside frame");
endmodule : echo_frontend_monitor
bind echo_frontend_config_regs echo_frontend_monitor mon (
   .clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
   .sclk_in(sclk_in), .sdi_in(sdi_in), .sdo_out(sdo_out),
   .sdo_oe_out(sdo_oe_out), .filter_ctrl_out(filter_ctrl_out),
   .logamp_ctrl_out(logamp_ctrl_out),
   .device_control_three_out(device_control_three_out));
`default_nettype wire

// [testbench/spi_host_model.sv]
/*
 Serial bus master model sending 16-bit access frames.
 Assumes the design samples its serial pins with clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire logic clk_in,
   input wire logic sdo_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic sdi_out
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wait_clk
   // ==========================================================
   // One access, MSB first, odd parity unless spoiled
   task automatic frame(input logic rd, input logic [5:0] addr,
      input logic [7:0] data, input logic spoil, output logic [15:0] resp);
      logic [15:0] word;
      word = {rd, addr, 1'b0, data};
      word[8] = ~^word ^ spoil;
      cs_n_out = 1'b0;
      wait_clk(4);
      for (int i = 15; i >= 0; i--) begin
         sdi_out = word[i];
         sclk_out = 1'b1;
         wait_clk(4);
         resp[i] = sdo_in;
         sclk_out = 1'b0;
         wait_clk(4);
      end
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out;
      wait_clk(4);
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [testbench/tb_echo_frontend_config_regs.sv]
/*
 Self-checking bench of the echo front-end register bank.
 Assumes the host model and the bound monitor are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_echo_frontend_config_regs;
   import echo_frontend_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cs_n, sclk, sdi, sdo, sdo_oe;
   filter_ctrl_t filt;
   logamp_ctrl_t lamp;
   logic [7:0] dc3;
   logic [7:0] shadow [64];
   logic [15:0] resp;
   int err_total = 0;
   int compares = 0;
   always #2.5 clk_in = ~clk_in;
   echo_frontend_config_regs uut (.clk_in(clk_in), .rstn_in(rstn_in),
      .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo),
      .sdo_oe_out(sdo_oe), .filter_ctrl_out(filt),
      .logamp_ctrl_out(lamp), .device_control_three_out(dc3));
   spi_host_model host (.clk_in(clk_in), .sdo_in(sdo), .cs_n_out(cs_n),
      .sclk_out(sclk), .sdi_out(sdi));
   // ==========================================================
   // Checking and expectations
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [7:0] wmask(input logic [5:0] a);
      case (a)
         6'h11: return 8'h3F;
         6'h13: return 8'hC7;
         6'h10, 6'h12, 6'h14: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction : wmask
   function automatic filter_ctrl_t exp_filt();
      logic [7:0] a;
      logic [7:0] b;
      a = shadow[16];
      b = shadow[17];
      return {a[6], (a[6] ? 2'h0 : b[5:4]),
         ((a[7] && !a[6]) ? a[5:0] + {2'h0, b[3:0]} : a[5:0])};
   endfunction : exp_filt
   function automatic logamp_ctrl_t exp_lamp();
      logic [7:0] s;
      logic [7:0] t;
      s = shadow[18];
      t = shadow[19];
      return {t[7], t[6], t[2], (s[7] ? s[6:0] : 7'h00), t[1:0]};
   endfunction : exp_lamp
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host.frame(1'b0, a, d, 1'b0, resp);
      shadow[a] = d & wmask(a);
      check({7'h0, filt}, {7'h0, exp_filt()});
      check({4'h0, lamp}, {4'h0, exp_lamp()});
      check({8'h0, dc3}, {8'h0, shadow[20]});
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic e);
      host.frame(1'b1, a, 8'h00, 1'b0, resp);
      check({8'h0, resp[7:0]}, {8'h0, shadow[a]});
      check({15'h0, resp[15]}, {15'h0, e});
   endtask : rd
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] d;
      for (int i = 0; i < 64; i++) shadow[i] = 8'h00;
      void'($urandom(33));
      repeat (3) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      check({7'h0, filt}, 16'h0000);
      check({4'h0, lamp}, 16'h0000);
      check({8'h0, dc3}, 16'h0000);
      for (int a = 16; a < 22; a++) rd(6'(a), 1'b0);
      for (int k = 0; k < 20; k++) begin
         for (int a = 16; a < 22; a++) begin
            d = (k < 8) ? {1'b1, 3'(k), 2'(k), 2'(k)} : 8'($urandom);
            wr(6'(a), d);
         end
         for (int a = 15; a < 22; a++) rd(6'(a), 1'b0);
      end
      rstn_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      for (int i = 0; i < 64; i++) shadow[i] = 8'h00;
      check({7'h0, filt}, 16'h0000);
      check({4'h0, lamp}, 16'h0000);
      check({8'h0, dc3}, 16'h0000);
      for (int a = 16; a < 22; a++) rd(6'(a), 1'b0);
      d = ~shadow[20];
      host.frame(1'b0, 6'h14, d, 1'b1, resp);
      check({8'h0, dc3}, {8'h0, shadow[20]});
      rd(6'h14, 1'b1);
      rd(6'h14, 1'b0);
      wrap_up();
   end
   initial begin
      repeat (80000) @(posedge clk_in);
      err_total++;
      wrap_up();
   end
endmodule : tb_echo_frontend_config_regs
`default_nettype wire
